// file: wvm_pkg.sv
// Constants shared by the weighted video mixer: widths, delay word layout,
// rounding tables, saturation limits and register map.
// Assumes a single pixel clock domain and a plain register port.
package wvm_pkg;
   // Datapath widths
   localparam int PIX_W = 12;
   localparam int OUT_W = 13;
   localparam int DLY_W = 3;
   localparam int DLY_MAX = 7;
   localparam int WORD_W = 15;

   // Delay word field positions
   localparam int FLD_A_LSB = 0;
   localparam int FLD_B_LSB = 3;
   localparam int FLD_M_LSB = 6;
   localparam int FLD_FMT_LSB = 9;
   localparam int FLD_RND_LSB = 12;
   localparam logic [14:0] WORD_RESET = 15'h0000;

   // Mix factor: one integer bit, eleven fraction bits
   localparam logic [11:0] MIX_ONE = 12'h800;

   // Rounding selector codes
   localparam logic [1:0] RND_8 = 2'h0;
   localparam logic [1:0] RND_10 = 2'h1;
   localparam logic [1:0] RND_12 = 2'h2;
   localparam logic [1:0] RND_13 = 2'h3;

   // Rounding increments in half-LSB units
   localparam logic signed [17:0] INC_8 = 18'sh00020;
   localparam logic signed [17:0] INC_10 = 18'sh00008;
   localparam logic signed [17:0] INC_12 = 18'sh00002;
   localparam logic signed [17:0] INC_13 = 18'sh00001;

   // Masks keeping the significant output bits
   localparam logic [12:0] MASK_8 = 13'h1FE0;
   localparam logic [12:0] MASK_10 = 13'h1FF8;
   localparam logic [12:0] MASK_12 = 13'h1FFE;
   localparam logic [12:0] MASK_13 = 13'h1FFF;

   // Saturation limits of the output formats
   localparam logic signed [16:0] SIGNED_MAX = 17'sh00FFF;
   localparam logic signed [16:0] SIGNED_MIN = -17'sh01000;
   localparam logic signed [16:0] UNSIGNED_MAX = 17'sh01FFF;
   localparam logic signed [16:0] UNSIGNED_MIN = 17'sh00000;
   localparam logic [12:0] OUT_SMAX = 13'h0FFF;
   localparam logic [12:0] OUT_SMIN = 13'h1000;
   localparam logic [12:0] OUT_UMAX = 13'h1FFF;
   localparam logic [12:0] OUT_UMIN = 13'h0000;

   // Register map, byte addresses
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_DELAY = 4'h4;
   localparam logic [3:0] REG_SHIFT = 4'h8;
   localparam int STAT_OVF_BIT = 0;
endpackage : wvm_pkg

// file: wvm_mixer.sv
// Weighted video mixer: pipelined weighted sum of two pixel streams with
// programmable per-input delay, rounding, saturation and a status port.
// Assumes all inputs arrive synchronous to sys_clk_i except the serial
// delay port and bypass, which are synchronised here.
// What this block does
// - Sample pixels, mix, format, round on clock
// - Two 12-bit pixel input buses
// - Mix factor unsigned, one integer bit
// - Mix factor MSB set forces exactly one
// - Mix enable low holds previous mix factor
// - Format select: one unsigned, zero signed
// - Format select travels with its pixels
// - Output is twice the weighted sum
// - Output format follows sampled input format
// - Detect overflow and saturate, never wrap
// - Round select picks 8/10/12/13 bits
// - Add half LSB, clear lower bits
// - Round select travels with its pixels
// - Output enable passed through to mixed_out_oe_n_o
// - Each input gets up to seven extra delays
// - Delay word in 15-bit serial shift register
// - Serial data enters first stage per strobe
// - Bypass forces delay word to zero
// - Six inherent pipeline stages to output
// - Five 3-bit delay fields, A lowest
`timescale 1ns/10ps

// Tapped delay line giving zero to seven extra cycles
module wvm_tap_delay #(
   parameter int W = 12
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] data_i,
   input wire logic [2:0] sel_i,
   output logic [W-1:0] data_o
);
   logic [W-1:0] stage_q [wvm_pkg::DLY_MAX];

   // Shift chain, every cycle
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage_q <= '{default: '0};
      end
      else
      begin
         stage_q[0] <= data_i;
         for (int i = 1; i < wvm_pkg::DLY_MAX; i++)
         begin
            stage_q[i] <= stage_q[i-1];
         end
      end
   end

   // Tap select, zero means straight through
   assign data_o = (sel_i == 3'h0) ? data_i : stage_q[sel_i - 3'h1];

   a_tap_one: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (sel_i == 3'h1 && !$past(rst_i)) |-> (data_o == $past(data_i)))
      else $error("one-cycle tap does not match previous input");
endmodule : wvm_tap_delay

module wvm_mixer (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [11:0] pixel_in_a_i,
   input wire logic [11:0] pixel_in_b_i,
   input wire logic [11:0] mix_factor_i,
   input wire logic mix_sample_enable_i,
   input wire logic input_format_sel_i,
   input wire logic [1:0] round_sel_i,
   input wire logic delay_load_strobe_n_i,
   input wire logic delay_serial_data_i,
   input wire logic delay_bypass_i,
   input wire logic output_enable_n_i,
   output logic [12:0] mixed_out_o,
   output logic mixed_out_oe_n_o,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o
);
   // Serial delay port synchronisers and shift register
   logic ld_meta_q, ld_sync_q, ld_prev_q;
   logic ser_meta_q, ser_sync_q;
   logic byp_meta_q, byp_sync_q;
   logic [14:0] shreg_q;
   logic [14:0] dly_word_q;
   logic ld_rise;

   // Stage 1 sample registers
   logic [11:0] a_s1_q, b_s1_q, m_s1_q;
   logic fmt_s1_q;
   logic [1:0] rnd_s1_q;

   // Delayed copies
   logic [11:0] a_dl, b_dl, m_dl;
   logic fmt_dl;
   logic [1:0] rnd_dl;

   // Stage 2..6
   logic [11:0] m_sat, m_cmp;
   logic signed [12:0] a_ext, b_ext;
   logic signed [12:0] a_s2_q, b_s2_q;
   logic [11:0] m_s2_q, mc_s2_q;
   logic fmt_s2_q, fmt_s3_q, fmt_s4_q, fmt_s5_q, fmt6_q;
   logic [1:0] rnd_s2_q, rnd_s3_q, rnd_s4_q, rnd_s5_q, rnd6_q;
   logic signed [25:0] pa_s3_q, pb_s3_q;
   logic signed [26:0] sum_s4_q;
   logic signed [17:0] half_w, round_inc, rsum;
   logic [12:0] mask_d, mask_s5_q;
   logic signed [16:0] r_s5_q;
   logic over_hi, over_lo, ovf;
   logic [12:0] hi_lim, lo_lim, out_d;
   logic [12:0] mixed_q;

   // Register port
   logic ovf_sticky_q;
   logic ovf_clr;
   logic [31:0] rd_sel;
   logic [31:0] rdata_q;
   logic [2:0] zrun_q;

   // Strobe, data and bypass brought into the pixel clock
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ld_meta_q <= 1'b1;
         ld_sync_q <= 1'b1;
         ld_prev_q <= 1'b1;
         ser_meta_q <= 1'b0;
         ser_sync_q <= 1'b0;
         byp_meta_q <= 1'b0;
         byp_sync_q <= 1'b0;
      end
      else
      begin
         ld_meta_q <= delay_load_strobe_n_i;
         ld_sync_q <= ld_meta_q;
         ld_prev_q <= ld_sync_q;
         ser_meta_q <= delay_serial_data_i;
         ser_sync_q <= ser_meta_q;
         byp_meta_q <= delay_bypass_i;
         byp_sync_q <= byp_meta_q;
      end
   end

   // Rising edge of the load strobe
   assign ld_rise = ld_sync_q & ~ld_prev_q;

   // Serial shift register, new bit enters at the top and walks down
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         shreg_q <= wvm_pkg::WORD_RESET;
         dly_word_q <= wvm_pkg::WORD_RESET;
      end
      else
      begin
         if (ld_rise)
            shreg_q <= {ser_sync_q, shreg_q[14:1]};
         dly_word_q <= byp_sync_q ? wvm_pkg::WORD_RESET : shreg_q;
      end
   end

   // Stage 1: input sampling, mix factor held when not enabled
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         a_s1_q <= 12'h000;
         b_s1_q <= 12'h000;
         m_s1_q <= 12'h000;
         fmt_s1_q <= 1'b0;
         rnd_s1_q <= 2'h0;
      end
      else
      begin
         a_s1_q <= pixel_in_a_i;
         b_s1_q <= pixel_in_b_i;
         fmt_s1_q <= input_format_sel_i;
         rnd_s1_q <= round_sel_i;
         if (mix_sample_enable_i)
            m_s1_q <= mix_factor_i;
      end
   end

   // Programmable extra delay for each input
   wvm_tap_delay #(.W(12)) u_dly_a (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .data_i(a_s1_q),
      .sel_i(dly_word_q[wvm_pkg::FLD_A_LSB +: wvm_pkg::DLY_W]),
      .data_o(a_dl)
   );
   wvm_tap_delay #(.W(12)) u_dly_b (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .data_i(b_s1_q),
      .sel_i(dly_word_q[wvm_pkg::FLD_B_LSB +: wvm_pkg::DLY_W]),
      .data_o(b_dl)
   );
   wvm_tap_delay #(.W(12)) u_dly_m (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .data_i(m_s1_q),
      .sel_i(dly_word_q[wvm_pkg::FLD_M_LSB +: wvm_pkg::DLY_W]),
      .data_o(m_dl)
   );
   wvm_tap_delay #(.W(1)) u_dly_fmt (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .data_i(fmt_s1_q),
      .sel_i(dly_word_q[wvm_pkg::FLD_FMT_LSB +: wvm_pkg::DLY_W]),
      .data_o(fmt_dl)
   );
   wvm_tap_delay #(.W(2)) u_dly_rnd (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .data_i(rnd_s1_q),
      .sel_i(dly_word_q[wvm_pkg::FLD_RND_LSB +: wvm_pkg::DLY_W]),
      .data_o(rnd_dl)
   );

   // Mix factor clamp and complement, pixel extension by format
   assign m_sat = m_dl[11] ? wvm_pkg::MIX_ONE : m_dl;
   assign m_cmp = wvm_pkg::MIX_ONE - m_sat;
   assign a_ext = fmt_dl ? $signed({1'b0, a_dl}) : $signed({a_dl[11], a_dl});
   assign b_ext = fmt_dl ? $signed({1'b0, b_dl}) : $signed({b_dl[11], b_dl});

   // Rounding increment and mask from the travelling selector
   assign round_inc = (rnd_s4_q == wvm_pkg::RND_8) ? wvm_pkg::INC_8 :
                      (rnd_s4_q == wvm_pkg::RND_10) ? wvm_pkg::INC_10 :
                      (rnd_s4_q == wvm_pkg::RND_12) ? wvm_pkg::INC_12 :
                      wvm_pkg::INC_13;
   assign mask_d = (rnd_s4_q == wvm_pkg::RND_8) ? wvm_pkg::MASK_8 :
                   (rnd_s4_q == wvm_pkg::RND_10) ? wvm_pkg::MASK_10 :
                   (rnd_s4_q == wvm_pkg::RND_12) ? wvm_pkg::MASK_12 :
                   wvm_pkg::MASK_13;

   // Sum in half-LSB units: times two, drop eleven fraction bits, keep one
   assign half_w = sum_s4_q[26:9];
   assign rsum = half_w + round_inc;

   // Stages 2 to 5: extend, multiply, add, round
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         a_s2_q <= 13'sh0000;
         b_s2_q <= 13'sh0000;
         m_s2_q <= 12'h000;
         mc_s2_q <= wvm_pkg::MIX_ONE;
         pa_s3_q <= 26'sh0000000;
         pb_s3_q <= 26'sh0000000;
         sum_s4_q <= 27'sh0000000;
         r_s5_q <= 17'sh00000;
         mask_s5_q <= wvm_pkg::MASK_13;
         {fmt_s2_q, fmt_s3_q, fmt_s4_q, fmt_s5_q} <= 4'h0;
         {rnd_s2_q, rnd_s3_q, rnd_s4_q, rnd_s5_q} <= 8'h00;
      end
      else
      begin
         a_s2_q <= a_ext;
         b_s2_q <= b_ext;
         m_s2_q <= m_sat;
         mc_s2_q <= m_cmp;
         pa_s3_q <= a_s2_q * $signed({1'b0, m_s2_q});
         pb_s3_q <= b_s2_q * $signed({1'b0, mc_s2_q});
         sum_s4_q <= pa_s3_q + pb_s3_q;
         r_s5_q <= rsum[17:1];
         mask_s5_q <= mask_d;
         {fmt_s2_q, fmt_s3_q, fmt_s4_q, fmt_s5_q} <= {fmt_dl, fmt_s2_q, fmt_s3_q, fmt_s4_q};
         {rnd_s2_q, rnd_s3_q, rnd_s4_q, rnd_s5_q} <=
            {rnd_dl, rnd_s2_q, rnd_s3_q, rnd_s4_q};
      end
   end

   // Overflow detection and clamp limits per output format
   assign over_hi = fmt_s5_q ? (r_s5_q > wvm_pkg::UNSIGNED_MAX)
                             : (r_s5_q > wvm_pkg::SIGNED_MAX);
   assign over_lo = fmt_s5_q ? (r_s5_q < wvm_pkg::UNSIGNED_MIN)
                             : (r_s5_q < wvm_pkg::SIGNED_MIN);
   assign ovf = over_hi | over_lo;
   assign hi_lim = (fmt_s5_q ? wvm_pkg::OUT_UMAX : wvm_pkg::OUT_SMAX) & mask_s5_q;
   assign lo_lim = fmt_s5_q ? wvm_pkg::OUT_UMIN : wvm_pkg::OUT_SMIN;
   assign out_d = over_hi ? hi_lim :
                  over_lo ? lo_lim :
                  (r_s5_q[12:0] & mask_s5_q);

   // Stage 6: output register and travelling selectors
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mixed_q <= 13'h0000;
         fmt6_q <= 1'b0;
         rnd6_q <= 2'h0;
      end
      else
      begin
         mixed_q <= out_d;
         fmt6_q <= fmt_s5_q;
         rnd6_q <= rnd_s5_q;
      end
   end

   assign mixed_out_o = mixed_q;
   // Enable passes straight through so it acts without the clock
   assign mixed_out_oe_n_o = output_enable_n_i;

   // Register port decode; sticky overflow set wins over clear
   assign ovf_clr = reg_wr_i && (reg_addr_i == wvm_pkg::REG_STATUS)
                    && reg_wdata_i[wvm_pkg::STAT_OVF_BIT];
   assign rd_sel = (reg_addr_i == wvm_pkg::REG_STATUS) ? {30'h00000000, byp_sync_q, ovf_sticky_q} :
                   (reg_addr_i == wvm_pkg::REG_DELAY) ? {17'h00000, dly_word_q} :
                   (reg_addr_i == wvm_pkg::REG_SHIFT) ? {17'h00000, shreg_q} :
                   32'h00000000;

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ovf_sticky_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         ovf_sticky_q <= ovf | (ovf_sticky_q & ~ovf_clr);
         rdata_q <= reg_rd_i ? rd_sel : 32'h00000000;
      end
   end

   assign reg_rdata_o = rdata_q;

   // Count of consecutive cycles with an all-zero delay word
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         zrun_q <= 3'h0;
      else if (dly_word_q != wvm_pkg::WORD_RESET)
         zrun_q <= 3'h0;
      else if (zrun_q != 3'h7)
         zrun_q <= zrun_q + 3'h1;
   end

   a_mix_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !mix_sample_enable_i |=> $stable(m_s1_q))
      else $error("mix factor changed while sampling disabled");

   a_mix_saturate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (m_dl[11] && !rst_i) |=> (m_s2_q == 12'h800))
      else $error("mix factor above one not clamped");

   a_mix_complement: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ((m_s2_q + mc_s2_q) == 12'h800) && (m_s2_q <= 12'h800))
      else $error("mix factor and complement do not sum to one");

   a_bypass_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      byp_sync_q |=> (dly_word_q == 15'h0000))
      else $error("delay word not cleared under bypass");

   a_shift_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ld_rise |=> (shreg_q == {$past(ser_sync_q), $past(shreg_q[14:1])}))
      else $error("serial word did not advance one place");

   a_round_eight: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rnd6_q == 2'h0) |-> (mixed_q[4:0] == 5'h00))
      else $error("low bits not cleared for eight-bit rounding");

   a_sat_signed: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (over_hi && !fmt_s5_q && rnd_s5_q == 2'h0) |=> (mixed_q == 13'h0FE0))
      else $error("signed positive overflow not clamped to maximum");

   a_fmt_track: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (zrun_q == 3'h7) |-> (fmt6_q == $past(fmt_s1_q, 5)))
      else $error("format selector lost step with its pixels");

   a_pass_b: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (m_s1_q == 12'h000 && rnd_s1_q == 2'h3 && fmt_s1_q)
      |-> ##5 ((zrun_q != 3'h7) || (mixed_q == {$past(b_s1_q, 5), 1'b0})))
      else $error("zero mix factor did not pass twice pixel B");

   a_sticky_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ovf |=> ovf_sticky_q)
      else $error("overflow event lost from status");
endmodule : wvm_mixer

// file: wvm_delay_loader.sv
// Behavioural model of the controller that loads the serial delay word.
// Assumes sys_clk_i is the mixer's pixel clock; all pacing is in its cycles.
`timescale 1ns/10ps

module wvm_delay_loader (
   input wire logic sys_clk_i,
   input wire logic start_i,
   input wire logic [14:0] word_i,
   output logic strobe_n_o,
   output logic data_o,
   output logic busy_o
);
   // Shift the word out, one bit per strobe rise, strobe three cycles high and six cycles low
   initial
   begin
      strobe_n_o = 1'b0;
      data_o = 1'b0;
      busy_o = 1'b0;
      forever
      begin
         @(posedge sys_clk_i);
         if (start_i)
         begin
            busy_o <= 1'b1;
            for (int i = 0; i < 15; i++)
            begin
               data_o <= word_i[i];
               repeat (3) @(posedge sys_clk_i);
               strobe_n_o <= 1'b1;
               repeat (3) @(posedge sys_clk_i);
               strobe_n_o <= 1'b0;
               repeat (2) @(posedge sys_clk_i);
               data_o <= ~word_i[i]; // Hold time over, bit no longer valid
               @(posedge sys_clk_i);
            end
            busy_o <= 1'b0;
         end
      end
   end
endmodule : wvm_delay_loader

// file: wvm_mixer_tb.sv
// Self-checking bench for the weighted video mixer: streams pixels against
// a reference model, loads delay words through the loader, reads registers.
// Assumes results appear five edges after sampling plus programmed delay.
`timescale 1ns/10ps

module wvm_mixer_tb;
   logic sys_clk_i, rst_i, mix_en, fmt, byp, oe_n, rd, wr, le, lf;
   logic [11:0] pa, pb, pm, la, lb, lm;
   logic [1:0] rnd, lr;
   logic [3:0] addr, nx_addr;
   logic [31:0] wdata, nx_wdata, reg_rdata;
   logic [12:0] mixed_out;
   wire [12:0] out_bus;
   logic out_oe_n, ld_strobe_n, ld_data, ld_start, ld_busy;
   logic nx_byp, nx_oe_n, nx_rd, nx_wr;
   logic [14:0] dw, cur_dw;
   int errors, n_checks, settle;
   int ha[8], hb[8], hm[8], hf[8], hr[8];
   logic [13:0] expq[$];
   logic [11:0] mt[6] = '{12'h000, 12'h200, 12'h400, 12'h600, 12'h800, 12'hC37};

   wvm_mixer wvm_mixer_inst (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pixel_in_a_i(pa), .pixel_in_b_i(pb),
      .mix_factor_i(pm), .mix_sample_enable_i(mix_en), .input_format_sel_i(fmt),
      .round_sel_i(rnd), .delay_load_strobe_n_i(ld_strobe_n), .delay_serial_data_i(ld_data),
      .delay_bypass_i(byp), .output_enable_n_i(oe_n), .mixed_out_o(mixed_out),
      .mixed_out_oe_n_o(out_oe_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(reg_rdata)
   );

   wvm_delay_loader wvm_delay_loader_inst (
      .sys_clk_i(sys_clk_i), .start_i(ld_start), .word_i(dw),
      .strobe_n_o(ld_strobe_n), .data_o(ld_data), .busy_o(ld_busy)
   );

   // Three-state output bus as the consumer sees it
   assign out_bus = out_oe_n ? 13'hZ : mixed_out;

   // Pixel clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // Reference result in half-LSB units, rounded then clamped
   function automatic logic [12:0] model(int a, int b, int mq, int f, int r);
      int inc[4] = '{32, 8, 2, 1};
      logic [12:0] mask[4] = '{13'h1FE0, 13'h1FF8, 13'h1FFE, 13'h1FFF};
      int ax, bx, h;
      ax = (f == 0 && a > 2047) ? a - 4096 : a;
      bx = (f == 0 && b > 2047) ? b - 4096 : b;
      h = (ax * mq + bx * (2048 - mq)) >>> 9;
      h = (h + inc[r]) >>> 1;
      if (h > (f ? 8191 : 4095))
         h = f ? 8191 : 4095;
      if (h < (f ? 0 : -4096))
         h = f ? 0 : -4096;
      return h[12:0] & mask[r];
   endfunction : model

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done;
      if (errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   // One pixel cycle: drive inputs, queue the expected result, compare
   task automatic step(logic [11:0] a, b, m, logic en, f, logic [1:0] r);
      int d[5];
      logic [13:0] e;
      @(posedge sys_clk_i);
      pa <= a;
      pb <= b;
      pm <= m;
      mix_en <= en;
      fmt <= f;
      rnd <= r;
      byp <= nx_byp;
      oe_n <= nx_oe_n;
      rd <= nx_rd;
      wr <= nx_wr;
      addr <= nx_addr;
      wdata <= nx_wdata;
      for (int i = 0; i < 5; i++)
         d[i] = nx_byp ? 0 : int'(cur_dw[3 * i +: 3]);
      for (int i = 7; i > 0; i--)
      begin
         ha[i] = ha[i - 1];
         hb[i] = hb[i - 1];
         hm[i] = hm[i - 1];
         hf[i] = hf[i - 1];
         hr[i] = hr[i - 1];
      end
      ha[0] = a;
      hb[0] = b;
      hm[0] = en ? (m[11] ? 2048 : int'(m)) : hm[1];
      hf[0] = f;
      hr[0] = r;
      e = {settle == 0, model(ha[d[0]], hb[d[1]], hm[d[2]], hf[d[3]], hr[d[4]])};
      if (settle > 0)
         settle--;
      expq.push_back(e);
      la = a;
      lb = b;
      lm = m;
      le = en;
      lf = f;
      lr = r;
      #1;
      if (expq.size() > 6)
      begin
         e = expq.pop_front();
         if (e[13])
            check("mixed_out", mixed_out, e[12:0]);
      end
      check("out_oe_n", out_oe_n, nx_oe_n);
      if (nx_oe_n)
         check("out_bus", {19'h0, out_bus}, {19'h0, 13'hZ});
   endtask : step

   task automatic idle;
      step(la, lb, lm, le, lf, lr);
   endtask : idle

   task automatic reg_read(logic [3:0] a, logic [31:0] exp);
      nx_rd = 1'b1;
      nx_addr = a;
      idle();
      nx_rd = 1'b0;
      idle();
      check("reg_rdata", reg_rdata, exp);
   endtask : reg_read

   task automatic reg_write(logic [3:0] a, logic [31:0] v);
      nx_wr = 1'b1;
      nx_addr = a;
      nx_wdata = v;
      idle();
      nx_wr = 1'b0;
   endtask : reg_write

   // Stream with rounding and mix factor changing each pixel, format every fourth, enable held high
   task automatic stream(int n);
      for (int i = 0; i < n; i++)
      begin
         nx_oe_n = (i % 5 == 4);
         step(12'h013 + 12'(i * 693), 12'h9A1 + 12'(i * 381), mt[i % 6],
              1'b1, i[2], i[1:0]);
      end
      nx_oe_n = 1'b0;
   endtask : stream

   // Main sequence
   initial
   begin
      errors = 0;
      n_checks = 0;
      settle = 8;
      {pa, pb, pm, la, lb, lm} = '0;
      {mix_en, fmt, rnd, le, lf, lr, oe_n, rd, wr, addr, wdata} = '0;
      {nx_oe_n, nx_rd, nx_wr, nx_addr, nx_wdata, ld_start} = '0;
      byp = 1'b1;
      nx_byp = 1'b1;
      cur_dw = 15'h0000;
      dw = {3'd5, 3'd2, 3'd4, 3'd1, 3'd7};
      rst_i = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      stream(48);
      step(12'hFFF, 12'hFFF, 12'h400, 1'b1, 1'b1, 2'h0);
      step(12'h7FF, 12'h7FF, 12'h400, 1'b1, 1'b0, 2'h0);
      step(12'h800, 12'h800, 12'h400, 1'b1, 1'b0, 2'h3);
      step(12'h5A3, 12'h2C4, 12'h9F0, 1'b1, 1'b1, 2'h3);
      step(12'h3B7, 12'h2C4, 12'h000, 1'b0, 1'b1, 2'h3);
      step(12'h3B7, 12'h2C4, 12'h200, 1'b0, 1'b0, 2'h2);
      step(12'h3B7, 12'h2C4, 12'h000, 1'b1, 1'b1, 2'h3);
      repeat (8) idle();
      reg_read(wvm_pkg::REG_STATUS, 32'h3);
      reg_write(wvm_pkg::REG_STATUS, 32'h1);
      reg_read(wvm_pkg::REG_STATUS, 32'h2);
      reg_write(wvm_pkg::REG_DELAY, 32'h7FFF);
      reg_read(wvm_pkg::REG_DELAY, 32'h0);
      reg_read(4'hC, 32'h0);
      // Release bypass and load the delay word serially
      nx_byp = 1'b0;
      settle = 100000;
      ld_start = 1'b1;
      idle();
      ld_start = 1'b0;
      for (int k = 0; k < 400 && ld_busy; k++)
         idle();
      cur_dw = dw;
      settle = 20;
      repeat (8) idle();
      reg_read(wvm_pkg::REG_DELAY, {17'h0, dw});
      reg_read(wvm_pkg::REG_SHIFT, {17'h0, dw});
      reg_read(wvm_pkg::REG_STATUS, 32'h0);
      stream(40);
      repeat (16) idle();
      test_done();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      #3000000;
      errors++;
      test_done();
   end
endmodule : wvm_mixer_tb
